// [gpx_pkg.sv]
// Constants and types shared by the GPIO expander blocks
`default_nettype none
package gpx_pkg;
   // Core clock and glitch filter timing
   localparam int CLK_NS = 50;
   localparam int REJECT_NS = 225;
   localparam int ACCEPT_NS = 1075;
   localparam int FILT_CYC = (REJECT_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int ACCEPT_CYC = ACCEPT_NS / CLK_NS;
   localparam logic [3:0] SETTLE_CYC = 4'(FILT_CYC + 3);
   // Pins and register map, one byte per address
   localparam int NPIN = 16;
   typedef logic [NPIN-1:0] pin_t;
   typedef logic [5:0] addr_t;
   typedef logic [7:0] byte_t;
   localparam addr_t A_STATE = 6'h00;
   localparam addr_t A_OUT = 6'h02;
   localparam addr_t A_INV = 6'h04;
   localparam addr_t A_DIR = 6'h06;
   localparam addr_t A_PULL = 6'h08;
   localparam addr_t A_IER = 6'h0a;
   localparam addr_t A_HIZ = 6'h0c;
   localparam addr_t A_FLAGS = 6'h0e;
   localparam addr_t A_RISE = 6'h10;
   localparam addr_t A_FALL = 6'h12;
   localparam addr_t A_FILT = 6'h14;
   // Command byte layout and bank halves
   localparam int CMD_RD_BIT = 7;
   localparam pin_t LOW_HALF = 16'h00ff;
   localparam pin_t HIGH_HALF = 16'hff00;
   // Reset values
   localparam pin_t RST_OUT = 16'hffff;
   localparam pin_t RST_DIR = 16'hffff;
   localparam pin_t RST_FILT = 16'hffff;
   localparam pin_t RST_OE_N = 16'hffff;
endpackage
`default_nettype wire

// [reg_chan_if.sv]
// Register request channel between the serial link and the register core
`default_nettype none
interface reg_chan_if;
   gpx_pkg::addr_t addr;
   logic rd_req;
   logic wr_req;
   gpx_pkg::byte_t wdata;
   gpx_pkg::byte_t rdata;
   modport link (output addr, output rd_req, output wr_req, output wdata, input rdata);
   modport core (input addr, input rd_req, input wr_req, input wdata, output rdata);
endinterface
`default_nettype wire

// [glitch_filter.sv]
// Per-pin input glitch filter with bypass
`default_nettype none
module glitch_filter (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic raw,
   input wire logic filt_en,
   output logic level
);
   import gpx_pkg::*;

   typedef struct packed {
      logic lvl;
      logic [2:0] cnt;
   } fst_t;

   fst_t q;
   fst_t d;

   // New level accepted only after FILT_CYC differing samples
   always_comb
   begin
      d = q;
      if (!filt_en)
      begin
         d.lvl = raw;
         d.cnt = 3'h0;
      end
      else if (raw == q.lvl)
         d.cnt = 3'h0;
      else if (q.cnt == 3'(FILT_CYC - 1))
      begin
         d.lvl = raw;
         d.cnt = 3'h0;
      end
      else
         d.cnt = q.cnt + 3'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         q <= '0;
      else if (clk_en)
         q <= d;
   end

   assign level = q.lvl;

   a_filter_hold: assert property (
      @(posedge core_clk) disable iff (rst || !clk_en)
      $past(filt_en) && $changed(q.lvl) |-> $past(q.cnt) == 3'(FILT_CYC - 1))
      else $error("filtered level moved before the hold count");
endmodule
`default_nettype wire

// [spi_link.sv]
// Serial link slave: command byte then one data byte per frame
`default_nettype none
module spi_link (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   reg_chan_if.link bus
);
   import gpx_pkg::*;

   typedef enum logic [1:0] {IDLE = 2'b00, CMD = 2'b01, DATA = 2'b11, DONE = 2'b10} ph_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic sclk_p;
      ph_t ph;
      logic [2:0] bitn;
      byte_t sh;
      byte_t so;
      logic rd;
      addr_t addr;
      byte_t wdata;
      logic miso;
      logic oe_n;
      logic rd_req;
      logic wr_req;
   } lst_t;

   localparam lst_t L_RST = '{s1: 3'h2, s2: 3'h2, ph: IDLE, oe_n: 1'b1, default: '0};

   lst_t q;
   lst_t d;
   logic rise;
   logic fall;

   // Edges of the synchronised link clock
   assign rise = q.s2[2] & ~q.sclk_p;
   assign fall = ~q.s2[2] & q.sclk_p;

   // Frame sequencer, sample on rising edge, shift out on falling
   always_comb
   begin
      d = q;
      d.rd_req = 1'b0;
      d.wr_req = 1'b0;
      d.s1 = {sclk, cs_n, mosi};
      d.s2 = q.s1;
      d.sclk_p = q.s2[2];
      if (q.s2[1])
      begin
         d.ph = IDLE;
         d.oe_n = 1'b1;
         d.bitn = 3'h0;
      end
      else
      begin
         unique case (q.ph)
            IDLE:
            begin
               d.ph = CMD;
               d.oe_n = 1'b0;
               d.bitn = 3'h0;
            end
            CMD:
               if (rise)
               begin
                  d.sh = {q.sh[6:0], q.s2[0]};
                  d.bitn = q.bitn + 3'h1;
                  if (q.bitn == 3'h7)
                  begin
                     d.rd = q.sh[CMD_RD_BIT-1];
                     d.addr = {q.sh[4:0], q.s2[0]};
                     d.rd_req = q.sh[CMD_RD_BIT-1];
                     d.ph = DATA;
                  end
               end
            DATA:
            begin
               if (fall)
               begin
                  d.so = (q.bitn == 3'h0) ? bus.rdata : {q.so[6:0], 1'b0};
                  d.miso = (q.bitn == 3'h0) ? bus.rdata[7] : q.so[6];
               end
               if (rise)
               begin
                  d.sh = {q.sh[6:0], q.s2[0]};
                  d.bitn = q.bitn + 3'h1;
                  if (q.bitn == 3'h7)
                  begin
                     d.wdata = {q.sh[6:0], q.s2[0]};
                     d.wr_req = ~q.rd;
                     d.ph = DONE;
                  end
               end
            end
            DONE: d.ph = DONE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         q <= L_RST;
      else if (clk_en)
         q <= d;
   end

   assign miso = q.miso;
   assign miso_oe_n = q.oe_n;
   assign bus.addr = q.addr;
   assign bus.rd_req = q.rd_req;
   assign bus.wr_req = q.wr_req;
   assign bus.wdata = q.wdata;
endmodule
`default_nettype wire

// [gpio16_expander_regs_irq.sv]
// Register core, pin control and interrupt logic of the 16-pin expander
`default_nettype none
module gpio16_expander_regs_irq (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   input wire gpx_pkg::pin_t gpio_in,
   output gpx_pkg::pin_t gpio_out,
   output gpx_pkg::pin_t gpio_oe_n,
   output gpx_pkg::pin_t pullup_on,
   output logic irq_n,
   output logic irq_oe_n
);
   import gpx_pkg::*;

   typedef struct packed {
      pin_t s1;
      pin_t s2;
      pin_t outl;
      pin_t inv;
      pin_t dir;
      pin_t pull;
      pin_t irq_enable;
      pin_t hiz;
      pin_t flags;
      pin_t rise;
      pin_t fall;
      pin_t filt;
      pin_t prev;
      pin_t snap;
      logic [3:0] settle;
      byte_t rdata;
      pin_t oe_n;
      pin_t pull_o;
      logic irq_n;
   } st_t;

   localparam st_t ST_RST = '{outl: RST_OUT, dir: RST_DIR, filt: RST_FILT,
                              oe_n: RST_OE_N, irq_n: 1'b1, default: '0};

   st_t q;
   st_t d;
   pin_t lvl;
   pin_t pstate;
   pin_t edge_r;
   pin_t edge_f;
   pin_t both;
   pin_t ev;
   pin_t ret;
   logic settled;
   logic hi;
   addr_t base;

   reg_chan_if chan ();

   // Serial register access
   spi_link u_link (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe_n(miso_oe_n),
      .bus(chan)
   );

   // One glitch filter per pin, fed by the synchronised pin
   for (genvar i = 0; i < NPIN; i++)
   begin : g_filt
      glitch_filter u_filt (
         .core_clk(core_clk),
         .rst(rst),
         .clk_en(clk_en),
         .raw(q.s2[i]),
         .filt_en(q.filt[i]),
         .level(lvl[i])
      );
   end

   // Bank select and register base address
   assign hi = chan.addr[0];
   assign base = {chan.addr[5:1], 1'b0};
   assign settled = (q.settle == SETTLE_CYC);

   // Pin-state value seen by a read
   assign pstate = (q.dir & (q.s2 ^ q.inv))
                 | (~q.dir & q.outl);

   // Edge detection and interrupt events
   assign edge_r = lvl & ~q.prev;
   assign edge_f = ~lvl & q.prev;
   assign both = ~(q.rise ^ q.fall);
   assign ev = {NPIN{settled}} & q.dir
             & q.irq_enable
             & ((both & (edge_r | edge_f))
             | (q.rise & ~q.fall & edge_r)
             | (q.fall & ~q.rise & edge_f));
   assign ret = both & ~(lvl ^ q.snap);

   // Byte lane helpers for the two banks
   function automatic pin_t put(pin_t v, logic h, byte_t b);
      return h ? {b, v[7:0]} : {v[15:8], b};
   endfunction

   function automatic byte_t get(pin_t v, logic h);
      return h ? v[15:8] : v[7:0];
   endfunction

   // Next state of the register core
   always_comb
   begin
      pin_t clr;
      pin_t rsel;
      clr = '0;
      rsel = '0;
      d = q;
      d.s1 = gpio_in;
      d.s2 = q.s1;
      d.prev = lvl;
      // Snapshot follows the input until filters settle after reset
      if (!settled)
      begin
         d.settle = q.settle + 4'h1;
         d.snap = lvl;
      end
      // Register writes
      if (chan.wr_req)
      begin
         unique case (base)
            A_OUT: d.outl = put(q.outl, hi, chan.wdata);
            A_INV: d.inv = put(q.inv, hi, chan.wdata);
            A_DIR: d.dir = put(q.dir, hi, chan.wdata);
            A_PULL: d.pull = put(q.pull, hi, chan.wdata);
            A_IER: d.irq_enable = put(q.irq_enable, hi, chan.wdata);
            A_HIZ: d.hiz = put(q.hiz, hi, chan.wdata);
            A_RISE: d.rise = put(q.rise, hi, chan.wdata);
            A_FALL: d.fall = put(q.fall, hi, chan.wdata);
            A_FILT: d.filt = put(q.filt, hi, chan.wdata);
            default: d.settle = d.settle;
         endcase
      end
      // Register reads
      unique case (base)
         A_STATE: rsel = pstate;
         A_OUT: rsel = q.outl;
         A_INV: rsel = q.inv;
         A_DIR: rsel = q.dir;
         A_PULL: rsel = q.pull;
         A_IER: rsel = q.irq_enable;
         A_HIZ: rsel = q.hiz;
         A_FLAGS: rsel = q.flags;
         A_RISE: rsel = q.rise;
         A_FALL: rsel = q.fall;
         A_FILT: rsel = q.filt;
         default: rsel = '0;
      endcase
      if (chan.rd_req)
      begin
         d.rdata = get(rsel, hi);
         if (base == A_STATE)
         begin
            clr = hi ? HIGH_HALF : LOW_HALF;
            d.snap = (q.snap & ~clr) | (lvl & clr);
         end
      end
      // Flags: a new event wins over any clear in the same cycle
      d.flags = ((q.flags & ~clr & ~ret) | ev) & q.dir;
      d.oe_n = d.dir | d.hiz;
      d.pull_o = d.pull & d.dir;
      d.irq_n = ~|d.flags;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         q <= ST_RST;
      else if (clk_en)
         q <= d;
   end

   // Outputs straight from flops
   assign chan.rdata = q.rdata;
   assign gpio_out = q.outl;
   assign gpio_oe_n = q.oe_n;
   assign pullup_on = q.pull_o;
   assign irq_n = q.irq_n;
   assign irq_oe_n = q.irq_n;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst || !clk_en);

   a_state_read: assert property (
      chan.rd_req && chan.addr == A_STATE |=> q.rdata == $past(pstate[7:0]))
      else $error("pin-state read returned wrong value");
   a_read_clears: assert property (
      chan.rd_req && chan.addr == A_STATE && ev[7:0] == 8'h00 |=> q.flags[7:0] == 8'h00)
      else $error("pin-state read did not clear low flags");
   a_out_readback: assert property (
      chan.rd_req && chan.addr == A_STATE && q.dir[0] == 1'b0 |=> q.rdata[0] == $past(q.outl[0]))
      else $error("output pin read did not return output level");
   a_state_wr_ignored: assert property (
      chan.wr_req && base == A_STATE
      |=> q.outl == $past(q.outl) && q.dir == $past(q.dir) && q.inv == $past(q.inv))
      else $error("pin-state write changed state");
   a_out_level_pin: assert property (
      chan.wr_req && chan.addr == A_OUT |=> gpio_out[7:0] == $past(chan.wdata))
      else $error("output level not driven");
   a_invert_read: assert property (
      chan.rd_req && chan.addr == A_STATE && q.dir[1] && q.inv[1]
      |=> q.rdata[1] == !$past(q.s2[1]))
      else $error("inverted read wrong");
   a_reset_values: assert property (
      $past(rst) |-> q.dir == RST_DIR && q.filt == RST_FILT)
      else $error("direction or filter reset wrong");
   a_ier_reset: assert property (
      $past(rst) |-> q.irq_enable == 16'h0000 && q.flags == 16'h0000)
      else $error("interrupt enables not cleared at reset");
   a_pullup_on: assert property (
      chan.wr_req && chan.addr == A_PULL && chan.wdata == 8'hff && q.dir[7:0] == 8'hff
      |=> pullup_on[7:0] == 8'hff)
      else $error("pull-ups not switched on");
   a_output_no_irq: assert property (
      1'b1 |=> (q.flags & ~$past(q.dir)) == 16'h0000)
      else $error("output pin flagged an interrupt");
   a_hiz_float: assert property (
      chan.wr_req && chan.addr == A_HIZ && chan.wdata == 8'hff |=> gpio_oe_n[7:0] == 8'hff)
      else $error("high impedance not applied");
   a_rise_irq: assert property (
      settled && q.dir[0] && q.irq_enable[0] && q.rise[0] && !q.fall[0] && edge_r[0] |=> q.flags[0])
      else $error("rising edge missed");
   a_fall_irq: assert property (
      settled && q.dir[0] && q.irq_enable[0] && q.fall[0] && !q.rise[0] && edge_f[0] |=> q.flags[0])
      else $error("falling edge missed");
   a_either_irq: assert property (
      settled && q.dir[0] && q.irq_enable[0] && both[0] && edge_f[0] |=> q.flags[0])
      else $error("either-edge mode missed a fall");
   a_return_clear: assert property (
      q.flags[0] && both[0] && lvl[0] == q.snap[0] && !ev[0] |=> !q.flags[0])
      else $error("return to read level did not clear flag");
   a_high_bank: assert property (
      chan.rd_req && chan.addr == (A_OUT | 6'h01) |=> q.rdata == $past(q.outl[15:8]))
      else $error("high bank mapping wrong");
   a_irq_level: assert property (
      q.flags != 16'h0000 |-> !irq_n && !irq_oe_n)
      else $error("interrupt line not asserted");
   a_bypass_path: assert property (
      !q.filt[0] ##1 !q.filt[0] |-> lvl[0] == $past(q.s2[0]))
      else $error("filter bypass lags");


   // Further register access checks
   a_high_state_read: assert property (
      chan.rd_req && chan.addr == (A_STATE | 6'h01) |=> q.rdata == $past(pstate[15:8]))
      else $error("high bank pin-state read wrong");
   a_high_clears: assert property (
      chan.rd_req && chan.addr == (A_STATE | 6'h01) && ev[15:8] == 8'h00
      |=> q.flags[15:8] == 8'h00)
      else $error("pin-state read did not clear high flags");
   a_invert_off: assert property (
      chan.rd_req && chan.addr == A_STATE && q.dir[1] && !q.inv[1]
      |=> q.rdata[1] == $past(q.s2[1]))
      else $error("true level read wrong");
   a_snap_on_read: assert property (
      chan.rd_req && chan.addr == A_STATE |=> q.snap[7:0] == $past(lvl[7:0]))
      else $error("read level not captured");

   // Further pin drive and clock enable checks
   a_output_drives: assert property (
      !q.dir[0] && !q.hiz[0] |-> !gpio_oe_n[0])
      else $error("output pin not driven");
   a_pull_off: assert property (
      chan.wr_req && chan.addr == A_PULL && chan.wdata == 8'h00 |=> pullup_on[7:0] == 8'h00)
      else $error("pull-ups not switched off");
   a_clk_en_freeze: assert property (
      disable iff (rst) !clk_en |=> q == $past(q))
      else $error("state moved while clock enable low");

   // Further interrupt checks
   a_event_sets: assert property (
      ev[0] |=> q.flags[0])
      else $error("event did not set flag");
   a_disabled_quiet: assert property (
      !q.flags[0] && !q.irq_enable[0] |=> !q.flags[0])
      else $error("disabled input flagged");
   a_either_rise: assert property (
      settled && q.dir[0] && q.irq_enable[0] && both[0] && edge_r[0] |=> q.flags[0])
      else $error("either-edge mode missed a rise");
   a_rise_only: assert property (
      settled && q.rise[0] && !q.fall[0] && edge_f[0] && !q.flags[0] |=> !q.flags[0])
      else $error("rising-only mode took a fall");
   a_single_keep: assert property (
      q.flags[0] && q.dir[0] && !both[0] && !(chan.rd_req && base == A_STATE && !hi)
      |=> q.flags[0])
      else $error("single-edge flag cleared without read");
   a_irq_release: assert property (
      q.flags == 16'h0000 |-> irq_n && irq_oe_n)
      else $error("interrupt line not released");

   c_read_clear: cover property (q.flags[0] ##1 chan.rd_req && chan.addr == A_STATE);
   c_either_return: cover property (q.flags[0] && both[0] ##1 !q.flags[0]);
   c_high_write: cover property (chan.wr_req && chan.addr == (A_DIR | 6'h01));
   c_rise_event: cover property (ev[0]);
   c_freeze: cover property (disable iff (rst) !clk_en ##1 clk_en);
endmodule
`default_nettype wire

// [spi_host_model.sv]
// Serial link host model that frames one register access at a time
`default_nettype none
module spi_host_model (
   input wire logic core_clk,
   input wire logic miso,
   output var logic sclk,
   output var logic cs_n,
   output var logic mosi
);
   timeunit 1ns;
   timeprecision 100ps;
   import gpx_pkg::*;

   // Idle levels: clock parked low, frame closed
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // Waits n core cycles, then steps just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Command byte then data byte, mode 0, MSB first, 400 ns link period
   task automatic frame(input logic rd, input addr_t a, input byte_t wd, output byte_t rd_o);
      logic [15:0] sh;
      sh = {rd, 1'b0, a, wd};
      rd_o = 8'h00;
      cs_n = 1'b0;
      cyc(4);
      for (int i = 15; i >= 0; i--)
      begin
         mosi = sh[i];
         cyc(4);
         // Read data sampled on the rising link edge
         if (i < 8)
            rd_o[i] = miso;
         sclk = 1'b1;
         cyc(4);
         sclk = 1'b0;
      end
      // Released data line must not keep showing the last bit
      mosi = ~mosi;
      cyc(4);
      cs_n = 1'b1;
      cyc(8);
   endtask
endmodule
`default_nettype wire

// [gpio16_expander_regs_irq_tb.sv]
// Self-checking bench for the 16-pin expander registers and interrupts
`default_nettype none
module gpio16_expander_regs_irq_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import gpx_pkg::*;

   `define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end

   logic core_clk;
   logic rst;
   logic clk_en;
   logic r;
   logic f;
   pin_t ext;
   wire logic sclk, cs_n, mosi, miso, miso_oe_n, irq_n, irq_oe_n;
   wire pin_t gpio_out, gpio_oe_n, pullup_on;
   // Pin level: device drives where enabled, outside world elsewhere
   wire pin_t gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ext);
   int num_errors = 0;
   int checks_done = 0;
   byte_t def_val [0:10] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hff};

   gpio16_expander_regs_irq gpio16_expander_regs_irq_inst (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe_n(miso_oe_n),
      .gpio_in(gpio_in),
      .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n),
      .pullup_on(pullup_on),
      .irq_n(irq_n),
      .irq_oe_n(irq_oe_n)
   );

   spi_host_model spi_host_model_inst (
      .core_clk(core_clk),
      .miso(miso),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi)
   );

   // Core clock, 50 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input addr_t a, input byte_t d);
      byte_t unused;
      spi_host_model_inst.frame(1'b0, a, d, unused);
   endtask

   task automatic chk_rd(input addr_t a, input byte_t e);
      byte_t v;
      spi_host_model_inst.frame(1'b1, a, 8'h00, v);
      `CHK(v, e)
   endtask

   // Interrupt line and its open-drain enable both follow the flags
   task automatic chk_irq(input logic e);
      `CHK(irq_n, ~e)
      `CHK(irq_oe_n, ~e)
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog against a hung frame
   initial
   begin
      repeat (40000) @(posedge core_clk);
      num_errors++;
      report_and_stop();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      clk_en = 1'b1;
      ext = 16'h3c5a;
      cyc(6);
      rst = 1'b0;
      cyc(3);
      `CHK(gpio_oe_n, RST_OE_N)
      `CHK(gpio_out, RST_OUT)
      `CHK(pullup_on, 16'h0000)
      `CHK(miso_oe_n, 1'b1)
      chk_irq(1'b0);
      // Writes to read-only places, then every reset value
      wr(A_STATE, 8'ha5);
      wr(A_STATE + 6'h01, 8'ha5);
      wr(A_FLAGS, 8'ha5);
      wr(A_FLAGS + 6'h01, 8'ha5);
      for (int a = 2; a < 22; a++)
         chk_rd(addr_t'(a), def_val[a / 2]);
      chk_rd(6'h16, 8'h00);
      chk_rd(6'h3f, 8'h00);
      chk_rd(A_STATE, ext[7:0]);
      chk_rd(A_STATE + 6'h01, ext[15:8]);
      // Read back each writable register, then restore it
      for (int a = 2; a < 22; a++)
      begin
         if (a == 14 || a == 15)
            continue;
         wr(addr_t'(a), byte_t'(8'h5a ^ a));
         chk_rd(addr_t'(a), byte_t'(8'h5a ^ a));
         wr(addr_t'(a), def_val[a / 2]);
      end
      // Outputs, high impedance and pull-ups in the high bank
      wr(A_DIR + 6'h01, 8'hf0);
      wr(A_OUT + 6'h01, 8'h05);
      wr(A_HIZ + 6'h01, 8'h01);
      wr(A_PULL + 6'h01, 8'hff);
      `CHK(gpio_out[15:8], 8'h05)
      `CHK(gpio_oe_n[15:8], 8'hf1)
      `CHK(pullup_on[15:8], 8'hf0)
      chk_rd(A_STATE + 6'h01, {ext[15:12], 4'h5});
      wr(A_INV, 8'hf0);
      chk_rd(A_STATE, ext[7:0] ^ 8'hf0);
      wr(A_INV, 8'h00);
      wr(A_DIR + 6'h01, 8'hff);
      wr(A_HIZ + 6'h01, 8'h00);
      wr(A_PULL + 6'h01, 8'h00);
      // Edge modes on pin 9, filter bypassed
      wr(A_FILT + 6'h01, 8'h00);
      wr(A_IER + 6'h01, 8'h02);
      for (int m = 0; m < 4; m++)
      begin
         r = m[0];
         f = m[1];
         wr(A_RISE + 6'h01, {6'h00, r, 1'b0});
         wr(A_FALL + 6'h01, {6'h00, f, 1'b0});
         chk_rd(A_STATE + 6'h01, 8'h3c);
         ext[9] = 1'b1;
         cyc(20);
         chk_irq(r | ~f);
         chk_rd(A_FLAGS + 6'h01, {6'h00, r | ~f, 1'b0});
         ext[9] = 1'b0;
         cyc(20);
         chk_irq(r ^ f);
         chk_rd(A_STATE, ext[7:0]);
         chk_irq(r ^ f);
         chk_rd(A_STATE + 6'h01, 8'h3c);
         cyc(5);
         chk_irq(1'b0);
      end
      // Filter on by default: short pulse rejected, long pulse accepted
      wr(A_RISE, 8'h01);
      wr(A_IER, 8'h01);
      ext[0] = 1'b1;
      cyc(4);
      ext[0] = 1'b0;
      cyc(30);
      chk_irq(1'b0);
      ext[0] = 1'b1;
      cyc(ACCEPT_CYC + 1);
      ext[0] = 1'b0;
      cyc(10);
      chk_irq(1'b1);
      chk_rd(A_FLAGS, 8'h01);
      chk_rd(A_STATE, ext[7:0]);
      cyc(5);
      chk_irq(1'b0);
      // Output pin and disabled input never interrupt
      wr(A_FILT, 8'h00);
      wr(A_RISE, 8'h0c);
      wr(A_FALL, 8'h0c);
      wr(A_DIR, 8'hfb);
      wr(A_IER, 8'h04);
      wr(A_OUT, 8'hfb);
      wr(A_OUT, 8'hff);
      ext[3] = ~ext[3];
      cyc(20);
      chk_irq(1'b0);
      chk_rd(A_FLAGS, 8'h00);
      // Clock enable low freezes the event path until released
      wr(A_IER, 8'h08);
      chk_rd(A_STATE, ext[7:0] | 8'h04);
      clk_en = 1'b0;
      ext[3] = ~ext[3];
      cyc(10);
      chk_irq(1'b0);
      clk_en = 1'b1;
      cyc(10);
      chk_irq(1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
